// ### hw/fas_access_chk.sv
// Protection decision for one latched flash request
`timescale 1ns/1ps
`default_nettype none
`include "fas_defs.svh"
module fas_access_chk
	import fas_pkg::*;
(
	// Request
	input wire logic from_dbg_i,
	input wire logic [1:0] dop_i,
	input wire logic [1:0] kind_i,
	input wire logic [15:0] addr_i,
	input wire logic [15:0] pc_i,
	// Protection state
	input wire logic [7:0] limit_i,
	input wire logic [7:0] rd_lock_i,
	input wire logic [7:0] wr_lock_i,
	input wire logic sel_i,
	input wire logic wen_i,
	input wire logic een_i,
	input wire logic fme_i,
	// Decision
	output logic refuse_o,
	output logic [1:0] fop_o,
	output logic scratch_o
);
	// Limit sits on 256-byte boundaries
	wire [15:0] lim_addr = {limit_i, 8'h00};
	wire is_rsv = addr_i >= `FAS_ADDR_RSV_BASE;
	wire is_lockbyte = (addr_i == `FAS_ADDR_RD_LOCK) | (addr_i == `FAS_ADDR_WR_LOCK);
	wire in_lockpage = addr_i[15:9] == `FAS_LOCK_PAGE;
	wire [2:0] blk = addr_i[15:13];
	// Fetch never sees the scratchpad sector
	wire is_scr = sel_i & ~from_dbg_i & (kind_i != `FAS_CPU_FETCH) & (addr_i[15:7] == `FAS_SCR_PAGE);
	wire lim_block = (pc_i >= lim_addr) & (addr_i < lim_addr) & ~is_scr;
	wire sw_erase = (kind_i == `FAS_CPU_XMOVE) & een_i;
	// Debug port, lock bytes themselves always reachable
	wire d_rd_ok = ~is_rsv & (rd_lock_i[blk] | is_lockbyte);
	wire d_wr_ok = ~is_rsv & (wr_lock_i[blk] | is_lockbyte);
	wire d_er_ok = is_lockbyte | (~is_rsv & wr_lock_i[blk]);
	wire d_ok = (dop_i == `FAS_DOP_READ) ? d_rd_ok :
		(dop_i == `FAS_DOP_WRITE) ? d_wr_ok :
		(dop_i == `FAS_DOP_ERASE) ? d_er_ok : 1'b0;
	// Firmware ignores lock bytes; xmove obeys enables, code and xmove obey the limit, fetch neither
	wire s_area_ok = is_scr | (~is_rsv & ~lim_block);
	wire s_ok = (kind_i == `FAS_CPU_FETCH) ? ~is_rsv :
		(kind_i == `FAS_CPU_CODE) ? s_area_ok :
		(kind_i == `FAS_CPU_XMOVE) ? (wen_i & fme_i & s_area_ok & ~(sw_erase & in_lockpage & ~is_scr)) :
		1'b0;
	wire [1:0] d_fop = (dop_i == `FAS_DOP_READ) ? `FAS_FOP_READ :
		(dop_i == `FAS_DOP_WRITE) ? `FAS_FOP_WRITE :
		is_lockbyte ? `FAS_FOP_MASS : `FAS_FOP_PAGE;
	wire [1:0] s_fop = (kind_i != `FAS_CPU_XMOVE) ? `FAS_FOP_READ :
		een_i ? `FAS_FOP_PAGE : `FAS_FOP_WRITE;
	assign refuse_o = from_dbg_i ? ~d_ok : ~s_ok;
	assign fop_o = from_dbg_i ? d_fop : s_fop;
	assign scratch_o = is_scr;
endmodule
`default_nettype wire

// ### hw/fas_ctl_if.sv
// Control and status bundle between the register slave and the access core
`timescale 1ns/1ps
`default_nettype none
interface fas_ctl_if;
	logic scratchpad_select;
	logic store_write_enable;
	logic store_erase_enable;
	logic flash_modify_enable;
	logic [7:0] read_limit;
	logic busy;
	logic last_refused;
	logic [7:0] rd_lock;
	logic [7:0] wr_lock;
	modport regs(output scratchpad_select, store_write_enable, store_erase_enable,
		flash_modify_enable, read_limit, input busy, last_refused, rd_lock, wr_lock);
	modport core(input scratchpad_select, store_write_enable, store_erase_enable,
		flash_modify_enable, read_limit, output busy, last_refused, rd_lock, wr_lock);
endinterface
`default_nettype wire

// ### hw/fas_defs.svh
// Address map, field positions and encodings for the flash access security block
`ifndef FAS_DEFS_SVH
`define FAS_DEFS_SVH
`define FAS_ADDR_RD_LOCK 16'hfdff
`define FAS_ADDR_WR_LOCK 16'hfdfe
`define FAS_ADDR_RSV_BASE 16'hfe00
`define FAS_LOCK_PAGE 7'h7e
`define FAS_SCR_PAGE 9'h000
`define FAS_BYTE_ERASED 8'hff
`define FAS_BYTE_ZERO 8'h00
`define FAS_LOCKS_AT_RESET 8'h00
`define FAS_LIMIT_AT_RESET 8'h00
`define FAS_FOP_READ 2'h0
`define FAS_FOP_WRITE 2'h1
`define FAS_FOP_PAGE 2'h2
`define FAS_FOP_MASS 2'h3
`define FAS_DOP_READ 2'h0
`define FAS_DOP_WRITE 2'h1
`define FAS_DOP_ERASE 2'h2
`define FAS_CPU_FETCH 2'h0
`define FAS_CPU_CODE 2'h1
`define FAS_CPU_XMOVE 2'h2
`define FAS_REG_PSC 6'h00
`define FAS_REG_FMC 6'h01
`define FAS_REG_LIM 6'h02
`define FAS_REG_STS 6'h03
`define FAS_PSC_WE 0
`define FAS_PSC_EE 1
`define FAS_PSC_SEL 2
`define FAS_FMC_EN 0
`endif

// ### hw/fas_pkg.sv
// Types shared by the flash access security modules
package fas_pkg;
	typedef enum logic [7:0] {
		ST_BOOT0 = 8'h01,
		ST_BOOT1 = 8'h02,
		ST_BOOT2 = 8'h04,
		ST_IDLE = 8'h08,
		ST_CHECK = 8'h10,
		ST_OLD = 8'h20,
		ST_FLASH = 8'h40,
		ST_REPLY = 8'h80
	} fas_state_t;
endpackage

// ### hw/fas_top.sv
// Flash access security core: arbitration, protection and flash sequencing
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "fas_defs.svh"
module fas_top
	import fas_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// Wishbone register port
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// CPU core requests
	input wire logic cpu_req_i,
	input wire logic [1:0] cpu_kind_i,
	input wire logic [15:0] cpu_addr_i,
	input wire logic [15:0] cpu_pc_i,
	input wire logic [7:0] cpu_wdata_i,
	output logic cpu_ack_o,
	output logic cpu_refused_o,
	// Debug port requests
	input wire logic dbg_req_i,
	input wire logic [1:0] dbg_op_i,
	input wire logic [15:0] dbg_addr_i,
	input wire logic [7:0] dbg_wdata_i,
	output logic dbg_ack_o,
	output logic dbg_refused_o,
	// Read data to both requesters
	output logic [7:0] rdata_o,
	// Flash macro
	output logic fl_start_o,
	output logic [1:0] fl_op_o,
	output logic fl_scratch_o,
	output logic [15:0] fl_addr_o,
	output logic [7:0] fl_wdata_o,
	input wire logic fl_done_i,
	input wire logic [7:0] fl_rdata_i
);
	fas_ctl_if ctl();

	fas_state_t state_q;
	fas_state_t state_d;

	// Latched request
	logic src_dbg_q;
	logic [1:0] dop_q;
	logic [1:0] kind_q;
	logic [15:0] addr_q;
	logic [15:0] pc_q;
	logic [7:0] wdata_q;

	// Lock byte shadows and reply flops
	logic [7:0] rd_lock_q;
	logic [7:0] wr_lock_q;
	logic refused_q;
	logic [7:0] rdata_q;
	logic cpu_ack_q;
	logic dbg_ack_q;
	logic dbg_refused_q;
	logic cpu_refused_q;

	// Flash command flops
	logic fl_start_q;
	logic [1:0] fl_op_q;
	logic fl_scr_q;
	logic [15:0] fl_addr_q;
	logic [7:0] fl_wdata_q;

	// Checker results
	logic chk_refuse;
	logic [1:0] chk_fop;
	logic chk_scr;

	fas_wb_regs u_regs (
		.core_clk_i(core_clk_i),
		.arst_n_i(arst_n_i),
		.wb_cyc_i(wb_cyc_i),
		.wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i),
		.wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i),
		.wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o),
		.ctl(ctl.regs)
	);

	fas_access_chk u_chk (
		.from_dbg_i(src_dbg_q),
		.dop_i(dop_q),
		.kind_i(kind_q),
		.addr_i(addr_q),
		.pc_i(pc_q),
		.limit_i(ctl.read_limit),
		.rd_lock_i(rd_lock_q),
		.wr_lock_i(wr_lock_q),
		.sel_i(ctl.scratchpad_select),
		.wen_i(ctl.store_write_enable),
		.een_i(ctl.store_erase_enable),
		.fme_i(ctl.flash_modify_enable),
		.refuse_o(chk_refuse),
		.fop_o(chk_fop),
		.scratch_o(chk_scr)
	);

	// Status back to the register file
	assign ctl.busy = state_q != ST_IDLE;
	assign ctl.last_refused = refused_q;
	assign ctl.rd_lock = rd_lock_q;
	assign ctl.wr_lock = wr_lock_q;

	// Request arbitration; debug wins so a runaway CPU cannot starve it
	wire take = (state_q == ST_IDLE) & (dbg_req_i | cpu_req_i);
	wire take_dbg = dbg_req_i;

	// Sequencing events
	wire done = fl_done_i;
	wire go_boot_rd = state_q == ST_BOOT0;
	wire go_boot_wr = (state_q == ST_BOOT1) & done;
	wire boot_end = (state_q == ST_BOOT2) & done;
	wire chk_pass = (state_q == ST_CHECK) & ~chk_refuse;
	wire go_old = chk_pass & (chk_fop == `FAS_FOP_WRITE);
	wire go_op = chk_pass & (chk_fop != `FAS_FOP_WRITE);
	wire go_prog = (state_q == ST_OLD) & done;
	wire op_end = (state_q == ST_FLASH) & done;
	wire go_reply = ((state_q == ST_CHECK) & chk_refuse) | op_end;
	wire any_start = go_boot_rd | go_boot_wr | go_old | go_op | go_prog;

	// Lock shadow maintenance after completed flash cycles
	wire lock_target = ~fl_scr_q;
	wire wr_rd_lock = op_end & lock_target & (fl_op_q == `FAS_FOP_WRITE) & (fl_addr_q == `FAS_ADDR_RD_LOCK);
	wire wr_wr_lock = op_end & lock_target & (fl_op_q == `FAS_FOP_WRITE) & (fl_addr_q == `FAS_ADDR_WR_LOCK);
	wire page_wipe = lock_target & (fl_op_q == `FAS_FOP_PAGE) & (fl_addr_q[15:9] == `FAS_LOCK_PAGE);
	wire lock_wipe = op_end & (page_wipe | (fl_op_q == `FAS_FOP_MASS));

	// Next-state logic
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_BOOT0: begin
				state_d = ST_BOOT1;
			end
			ST_BOOT1: begin
				if (done) begin
					state_d = ST_BOOT2;
				end
			end
			ST_BOOT2: begin
				if (done) begin
					state_d = ST_IDLE;
				end
			end
			ST_IDLE: begin
				if (take) begin
					state_d = ST_CHECK;
				end
			end
			ST_CHECK: begin
				if (chk_refuse) begin
					state_d = ST_REPLY;
				end else if (chk_fop == `FAS_FOP_WRITE) begin
					state_d = ST_OLD;
				end else begin
					state_d = ST_FLASH;
				end
			end
			ST_OLD: begin
				if (done) begin
					state_d = ST_FLASH;
				end
			end
			ST_FLASH: begin
				if (done) begin
					state_d = ST_REPLY;
				end
			end
			ST_REPLY: begin
				state_d = ST_IDLE;
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// State register
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= ST_BOOT0;
		end else begin
			state_q <= state_d;
		end
	end

	// Capture the winning request
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			src_dbg_q <= 1'b0;
			dop_q <= `FAS_DOP_READ;
			kind_q <= `FAS_CPU_FETCH;
			addr_q <= 16'h0;
			pc_q <= 16'h0;
			wdata_q <= `FAS_BYTE_ZERO;
		end else if (take) begin
			src_dbg_q <= take_dbg;
			dop_q <= dbg_op_i;
			kind_q <= cpu_kind_i;
			addr_q <= take_dbg ? dbg_addr_i : cpu_addr_i;
			pc_q <= cpu_pc_i;
			wdata_q <= take_dbg ? dbg_wdata_i : cpu_wdata_i;
		end
	end

	// Flash command; start is a one-cycle pulse per cycle of the macro
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			fl_start_q <= 1'b0;
			fl_op_q <= `FAS_FOP_READ;
			fl_scr_q <= 1'b0;
			fl_addr_q <= 16'h0;
			fl_wdata_q <= `FAS_BYTE_ERASED;
		end else begin
			fl_start_q <= any_start;
			if (go_boot_rd) begin
				fl_op_q <= `FAS_FOP_READ;
				fl_scr_q <= 1'b0;
				fl_addr_q <= `FAS_ADDR_RD_LOCK;
			end else if (go_boot_wr) begin
				fl_addr_q <= `FAS_ADDR_WR_LOCK;
			end else if (go_old) begin
				fl_op_q <= `FAS_FOP_READ;
				fl_scr_q <= chk_scr;
				fl_addr_q <= addr_q;
			end else if (go_op) begin
				fl_op_q <= chk_fop;
				fl_scr_q <= chk_scr;
				fl_addr_q <= addr_q;
			end else if (go_prog) begin
				fl_op_q <= `FAS_FOP_WRITE;
				fl_wdata_q <= fl_rdata_i & wdata_q;
			end
		end
	end

	// Lock byte shadows; loaded at boot, locked until then
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rd_lock_q <= `FAS_LOCKS_AT_RESET;
			wr_lock_q <= `FAS_LOCKS_AT_RESET;
		end else if (lock_wipe) begin
			rd_lock_q <= `FAS_BYTE_ERASED;
			wr_lock_q <= `FAS_BYTE_ERASED;
		end else begin
			if (go_boot_wr) begin
				rd_lock_q <= fl_rdata_i;
			end else if (wr_rd_lock) begin
				rd_lock_q <= fl_wdata_q;
			end
			if (boot_end) begin
				wr_lock_q <= fl_rdata_i;
			end else if (wr_wr_lock) begin
				wr_lock_q <= fl_wdata_q;
			end
		end
	end

	// Reply; refused reads answer zero rather than stale data
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cpu_ack_q <= 1'b0;
			dbg_ack_q <= 1'b0;
			cpu_refused_q <= 1'b0;
			dbg_refused_q <= 1'b0;
			refused_q <= 1'b0;
			rdata_q <= `FAS_BYTE_ZERO;
		end else begin
			cpu_ack_q <= go_reply & ~src_dbg_q;
			dbg_ack_q <= go_reply & src_dbg_q;
			cpu_refused_q <= go_reply & ~src_dbg_q & ~op_end;
			dbg_refused_q <= go_reply & src_dbg_q & ~op_end;
			if (go_reply) begin
				refused_q <= ~op_end;
			end
			if (op_end && fl_op_q == `FAS_FOP_READ) begin
				rdata_q <= fl_rdata_i;
			end else if (go_reply) begin
				rdata_q <= `FAS_BYTE_ZERO;
			end
		end
	end

	// Outputs straight from flops
	assign cpu_ack_o = cpu_ack_q;
	assign dbg_ack_o = dbg_ack_q;
	assign cpu_refused_o = cpu_refused_q;
	assign dbg_refused_o = dbg_refused_q;
	assign rdata_o = rdata_q;
	assign fl_start_o = fl_start_q;
	assign fl_op_o = fl_op_q;
	assign fl_scratch_o = fl_scr_q;
	assign fl_addr_o = fl_addr_q;
	assign fl_wdata_o = fl_wdata_q;
endmodule
`default_nettype wire

// ### hw/fas_wb_regs.sv
// Classic Wishbone register slave for the flash access security block
`timescale 1ns/1ps
`default_nettype none
`include "fas_defs.svh"
module fas_wb_regs
	import fas_pkg::*;
(
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// Wishbone slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Control bundle
	fas_ctl_if.regs ctl
);
	logic [2:0] psc_q;
	logic fme_q;
	logic [7:0] lim_q;
	logic ack_q;
	logic [31:0] dat_q;
	// Decode; word index is byte address over four
	wire acc = wb_cyc_i & wb_stb_i & ~ack_q;
	wire [5:0] idx = wb_adr_i[7:2];
	wire wr_lo = acc & wb_we_i & wb_sel_i[0];
	wire [31:0] rd_word = (idx == `FAS_REG_PSC) ? {29'h0, psc_q} :
		(idx == `FAS_REG_FMC) ? {31'h0, fme_q} :
		(idx == `FAS_REG_LIM) ? {24'h0, lim_q} :
		(idx == `FAS_REG_STS) ? {14'h0, ctl.last_refused, ctl.busy, ctl.wr_lock, ctl.rd_lock} :
		32'h0;
	assign ctl.store_write_enable = psc_q[`FAS_PSC_WE];
	assign ctl.store_erase_enable = psc_q[`FAS_PSC_EE];
	assign ctl.scratchpad_select = psc_q[`FAS_PSC_SEL];
	assign ctl.flash_modify_enable = fme_q;
	assign ctl.read_limit = lim_q;
	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;
	// One-cycle answer to every access, unmapped reads give zero
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0;
			psc_q <= 3'h0;
			fme_q <= 1'b0;
			lim_q <= `FAS_LIMIT_AT_RESET;
		end else begin
			ack_q <= acc;
			dat_q <= acc ? rd_word : 32'h0;
			if (wr_lo && idx == `FAS_REG_PSC) begin
				psc_q <= wb_dat_i[2:0];
			end
			if (wr_lo && idx == `FAS_REG_FMC) begin
				fme_q <= wb_dat_i[`FAS_FMC_EN];
			end
			if (wr_lo && idx == `FAS_REG_LIM) begin
				lim_q <= wb_dat_i[7:0];
			end
		end
	end
endmodule
`default_nettype wire

// ### verification/fas_flash_model.sv
// Behavioural flash macro that answers the access core's cycles
`timescale 1ns/1ps
`default_nettype none
module fas_flash_model #(
	parameter int DELAY = 3
) (
	// Clock
	input wire logic core_clk_i,
	// Cycle request
	input wire logic fl_start_i,
	input wire logic [1:0] fl_op_i,
	input wire logic fl_scratch_i,
	input wire logic [15:0] fl_addr_i,
	input wire logic [7:0] fl_wdata_i,
	// Answer
	output logic fl_done_o,
	output logic [7:0] fl_rdata_o
);
	logic [7:0] mem [0:65535];
	logic [7:0] spad [0:127];
	// Blank array, everything erased
	initial begin
		fl_done_o = 1'b0;
		fl_rdata_o = 8'h00;
		foreach (mem[i]) mem[i] = 8'hff;
		foreach (spad[i]) spad[i] = 8'hff;
	end
	// One cycle at a time; read data is garbage outside the done cycle
	always @(posedge core_clk_i) begin
		if (fl_start_i) begin
			repeat (DELAY) @(posedge core_clk_i);
			case (fl_op_i)
				2'h0: fl_rdata_o <= fl_scratch_i ? spad[fl_addr_i[6:0]] : mem[fl_addr_i];
				2'h1: begin
					if (fl_scratch_i) spad[fl_addr_i[6:0]] = spad[fl_addr_i[6:0]] & fl_wdata_i;
					else mem[fl_addr_i] = mem[fl_addr_i] & fl_wdata_i;
				end
				2'h2: begin
					if (fl_scratch_i) foreach (spad[i]) spad[i] = 8'hff;
					else for (int i = 0; i < 512; i++) mem[{fl_addr_i[15:9], 9'h000} + i] = 8'hff;
				end
				default: for (int i = 0; i < 32'hfe00; i++) mem[i] = 8'hff;
			endcase
			fl_done_o <= 1'b1;
			@(posedge core_clk_i);
			fl_done_o <= 1'b0;
			fl_rdata_o <= ~fl_rdata_o;
		end
	end
endmodule
`default_nettype wire

// ### verification/fas_top_bench.sv
// Self-checking bench for the flash access security top
`timescale 1ns/1ps
`default_nettype none
`include "fas_defs.svh"
module fas_top_bench;
	logic core_clk_i = 1'b0, arst_n_i = 1'b0;
	logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
	logic [7:0] wb_adr_i = 8'h00;
	logic [3:0] wb_sel_i = 4'hf;
	logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
	logic wb_ack_o, cpu_ack_o, cpu_refused_o, dbg_ack_o, dbg_refused_o;
	logic cpu_req_i = 1'b0, dbg_req_i = 1'b0;
	logic [1:0] cpu_kind_i = 2'h0, dbg_op_i = 2'h0, fl_op_o;
	logic [15:0] cpu_addr_i = 16'h0, cpu_pc_i = 16'h0, dbg_addr_i = 16'h0, fl_addr_o;
	logic [7:0] cpu_wdata_i = 8'h0, dbg_wdata_i = 8'h0, rdata_o, fl_wdata_o, fl_rdata_i;
	logic fl_start_o, fl_scratch_o, fl_done_i;
	int n_errors = 0, total_checks = 0;
	always #2.5 core_clk_i = ~core_clk_i;
	fas_top uut (.core_clk_i, .arst_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
		.wb_dat_o, .wb_ack_o, .cpu_req_i, .cpu_kind_i, .cpu_addr_i, .cpu_pc_i, .cpu_wdata_i, .cpu_ack_o,
		.cpu_refused_o, .dbg_req_i, .dbg_op_i, .dbg_addr_i, .dbg_wdata_i, .dbg_ack_o, .dbg_refused_o, .rdata_o,
		.fl_start_o, .fl_op_o, .fl_scratch_o, .fl_addr_o, .fl_wdata_o, .fl_done_i, .fl_rdata_i);
	fas_flash_model flash (.core_clk_i, .fl_start_i(fl_start_o), .fl_op_i(fl_op_o), .fl_scratch_i(fl_scratch_o),
		.fl_addr_i(fl_addr_o), .fl_wdata_i(fl_wdata_o), .fl_done_o(fl_done_i), .fl_rdata_o(fl_rdata_i));
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Classic single Wishbone cycle, held until ack is sampled
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge core_clk_i);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= w;
		wb_adr_i <= a;
		wb_dat_i <= d;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		q = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		if (n >= 50) begin
			n_errors++;
			final_report();
		end
	endtask
	// One CPU or debug request, held until its ack; refusal and data checked there
	task automatic acc(input logic d, input logic [1:0] op, input logic [15:0] a, input logic [15:0] pc,
		input logic [7:0] wd, input logic eref, input logic [7:0] erd, input logic crd);
		int n = 0;
		@(posedge core_clk_i);
		if (d) begin
			dbg_req_i <= 1'b1;
			dbg_op_i <= op;
			dbg_addr_i <= a;
			dbg_wdata_i <= wd;
		end else begin
			cpu_req_i <= 1'b1;
			cpu_kind_i <= op;
			cpu_addr_i <= a;
			cpu_pc_i <= pc;
			cpu_wdata_i <= wd;
		end
		do begin
			@(posedge core_clk_i);
			n++;
		end while ((d ? dbg_ack_o : cpu_ack_o) !== 1'b1 && n < 200);
		chk("refused", {31'h0, eref}, {31'h0, d ? dbg_refused_o : cpu_refused_o});
		if (crd) chk("rdata", {24'h0, erd}, {24'h0, rdata_o});
		dbg_req_i <= 1'b0;
		cpu_req_i <= 1'b0;
		if (n >= 200) begin
			n_errors++;
			final_report();
		end
	endtask
	task dr(input logic [15:0] a, input logic e, input logic [7:0] v);
		acc(1'b1, `FAS_DOP_READ, a, 16'h0, 8'h00, e, v, 1'b1);
	endtask
	task dw(input logic [15:0] a, input logic [7:0] v, input logic e);
		acc(1'b1, `FAS_DOP_WRITE, a, 16'h0, v, e, 8'h00, 1'b0);
	endtask
	task de(input logic [15:0] a, input logic e);
		acc(1'b1, `FAS_DOP_ERASE, a, 16'h0, 8'h00, e, 8'h00, 1'b0);
	endtask
	task cr(input logic [15:0] a, input logic [15:0] pc, input logic e, input logic [7:0] v);
		acc(1'b0, `FAS_CPU_CODE, a, pc, 8'h00, e, v, 1'b1);
	endtask
	task cw(input logic [15:0] a, input logic [15:0] pc, input logic [7:0] v, input logic e);
		acc(1'b0, `FAS_CPU_XMOVE, a, pc, v, e, 8'h00, 1'b0);
	endtask
	// Main sequence; the first request also waits out the boot reads
	initial begin
		repeat (20) @(posedge core_clk_i);
		arst_n_i <= 1'b1;
		dw(16'h1234, 8'h5a, 1'b0);
		dr(16'h1234, 1'b0, 8'h5a);
		dw(16'h1234, 8'hf0, 1'b0);
		dr(16'h1234, 1'b0, 8'h50);
		dr(16'hfe00, 1'b1, 8'h00);
		dw(16'hff00, 8'h00, 1'b1);
		de(16'hfe00, 1'b1);
		// Undefined operation codes on either port must be refused
		acc(1'b1, 2'h3, 16'h1234, 16'h0, 8'h00, 1'b1, 8'h00, 1'b1);
		acc(1'b0, 2'h3, 16'h1234, 16'h0, 8'h00, 1'b1, 8'h00, 1'b1);
		wb(1'b0, 8'h08, 32'h0);
		chk("limit", 32'h0, q);
		// Bit 17 still holds the refusal that was answered last
		wb(1'b0, 8'h0c, 32'h0);
		chk("status", 32'h0002ffff, q);
		wb(1'b0, 8'h40, 32'h0);
		chk("unmapped", 32'h0, q);
		$display("debug and registers done");
		cr(16'h1234, 16'h8000, 1'b0, 8'h50);
		wb(1'b1, 8'h08, 32'h20);
		cr(16'h1234, 16'h3000, 1'b1, 8'h00);
		cr(16'h1fff, 16'h2000, 1'b1, 8'h00);
		cr(16'h2000, 16'h3000, 1'b0, 8'hff);
		cr(16'h1234, 16'h1fff, 1'b0, 8'h50);
		acc(1'b0, `FAS_CPU_FETCH, 16'h1234, 16'h3000, 8'h00, 1'b0, 8'h50, 1'b1);
		$display("read limit done");
		cw(16'h3000, 16'h3000, 8'ha5, 1'b1);
		wb(1'b1, 8'h00, 32'h1);
		cw(16'h3000, 16'h3000, 8'ha5, 1'b1);
		wb(1'b1, 8'h04, 32'h1);
		cw(16'h3000, 16'h3000, 8'ha5, 1'b0);
		cr(16'h3000, 16'h3000, 1'b0, 8'ha5);
		cw(16'h1000, 16'h3000, 8'h00, 1'b1);
		cw(16'hfc10, 16'h3000, 8'h0f, 1'b0);
		wb(1'b1, 8'h00, 32'h3);
		cw(16'hfc10, 16'h3000, 8'h00, 1'b1);
		cw(16'h3000, 16'h3000, 8'h00, 1'b0);
		cr(16'h3000, 16'h3000, 1'b0, 8'hff);
		wb(1'b1, 8'h00, 32'h5);
		cw(16'h0010, 16'h3000, 8'h33, 1'b0);
		cr(16'h0010, 16'h3000, 1'b0, 8'h33);
		acc(1'b0, `FAS_CPU_FETCH, 16'h0010, 16'h0000, 8'h00, 1'b0, 8'hff, 1'b1);
		$display("firmware access done");
		dw(16'hfdff, 8'hfe, 1'b0);
		wb(1'b0, 8'h0c, 32'h0);
		chk("status", 32'h0000fffe, q);
		dr(16'h1234, 1'b1, 8'h00);
		dr(16'h2000, 1'b0, 8'hff);
		cr(16'h1234, 16'h0000, 1'b0, 8'h50);
		dr(16'hfdff, 1'b0, 8'hfe);
		dw(16'hfdfe, 8'h7f, 1'b0);
		de(16'hfc00, 1'b1);
		de(16'hfdfe, 1'b0);
		dr(16'h1234, 1'b0, 8'hff);
		wb(1'b0, 8'h0c, 32'h0);
		chk("status", 32'h0000ffff, q);
		dw(16'h1234, 8'h11, 1'b0);
		dw(16'hfdff, 8'hfe, 1'b0);
		de(16'hfc00, 1'b0);
		wb(1'b0, 8'h0c, 32'h0);
		chk("status", 32'h0000ffff, q);
		dr(16'h1234, 1'b0, 8'h11);
		$display("lock bytes done");
		final_report();
	end
endmodule
bind fas_top fas_top_properties u_props (.core_clk_i, .arst_n_i, .dbg_req_i, .cpu_ack_o, .cpu_refused_o,
	.dbg_ack_o, .dbg_refused_o, .rdata_o, .fl_start_o, .fl_op_o, .fl_scratch_o, .fl_addr_o, .fl_wdata_o,
	.fl_done_i, .fl_rdata_i);
`default_nettype wire

// ### verification/fas_top_properties.sv
// Concurrent checks on the flash access security top ports
`timescale 1ns/1ps
`default_nettype none
module fas_top_properties (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic arst_n_i,
	// Requesters
	input wire logic dbg_req_i,
	input wire logic cpu_ack_o,
	input wire logic cpu_refused_o,
	input wire logic dbg_ack_o,
	input wire logic dbg_refused_o,
	input wire logic [7:0] rdata_o,
	// Flash macro
	input wire logic fl_start_o,
	input wire logic [1:0] fl_op_o,
	input wire logic fl_scratch_o,
	input wire logic [15:0] fl_addr_o,
	input wire logic [7:0] fl_wdata_o,
	input wire logic fl_done_i,
	input wire logic [7:0] fl_rdata_i
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!arst_n_i);
	logic busy_q;
	logic [7:0] old_q;
	// Outstanding macro cycle and last byte read back, the base of a write
	always_ff @(posedge core_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			busy_q <= 1'b0;
			old_q <= 8'h00;
		end else begin
			busy_q <= fl_start_o | (busy_q & ~fl_done_i);
			if (fl_done_i) old_q <= fl_rdata_i;
		end
	end
	property p_one_cycle;
		fl_start_o |-> !busy_q;
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("flash start while a cycle runs");
	property p_refuse_quiet;
		(cpu_refused_o || dbg_refused_o) |-> !$past(fl_start_o) && !$past(fl_start_o, 2);
	endproperty
	a_refuse_quiet: assert property (p_refuse_quiet) else $error("refused access started flash");
	property p_refuse_zero;
		(cpu_refused_o || dbg_refused_o) |-> rdata_o == 8'h00 && (cpu_ack_o || dbg_ack_o);
	endproperty
	a_refuse_zero: assert property (p_refuse_zero) else $error("refusal without ack or zero data");
	property p_dbg_after_done;
		dbg_ack_o && !dbg_refused_o |-> $past(fl_done_i);
	endproperty
	a_dbg_after_done: assert property (p_dbg_after_done) else $error("debug ack without flash cycle");
	property p_reserved;
		fl_start_o && fl_op_o != 2'h3 && !fl_scratch_o |-> fl_addr_o < 16'hfe00;
	endproperty
	a_reserved: assert property (p_reserved) else $error("flash cycle in reserved area");
	property p_scratch_range;
		fl_start_o && fl_scratch_o |-> fl_addr_o < 16'h0080;
	endproperty
	a_scratch_range: assert property (p_scratch_range) else $error("scratchpad cycle out of range");
	property p_clear_only;
		fl_start_o && fl_op_o == 2'h1 |-> (fl_wdata_o & ~old_q) == 8'h00;
	endproperty
	a_clear_only: assert property (p_clear_only) else $error("byte write would set bits");
	property p_mass_dbg;
		fl_start_o && fl_op_o == 2'h3 |-> $past(dbg_req_i);
	endproperty
	a_mass_dbg: assert property (p_mass_dbg) else $error("whole erase not from debug port");
endmodule
`default_nettype wire
